// >>> dv/sccs_ext_clk_model.sv
// behavioural external clock part (crystal, rc or cmos clock) on oscillator pin one
`timescale 1ns/1ps
module sccs_ext_clk_model (
  // control from the bench
  input wire logic run,
  input wire logic [15:0] half_ns,
  // pin drive
  output logic pin
);
  // first edge lands 2 ns after run rises so it never meets a sys_clk edge;
  // a stopped part parks low, so no stray edge reaches the synchroniser
  initial pin = 1'b0;
  always
  begin
    @(posedge run);
    #2;
    while (run)
    begin
      pin = ~pin;
      #(half_ns);
    end
    pin = 1'b0;
  end
endmodule

// >>> dv/sccs_top_tb.sv
// self-checking bench for the system clock source control block
`timescale 1ns/1ps
module sccs_top_tb;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int MCD = 300;
  localparam logic [7:0] A_X = 8'hB1;
  localparam logic [7:0] A_I = 8'hB2;
  logic sys_clk = 1'b0;
  logic rst;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, osc_pin_one_o, osc_pin_one_oe, model_pin, ext_run;
  logic sysclk_tick, sysclk_ext, int_osc_on, ext_osc_on, mcd_reset;
  logic pin_wire;
  logic [7:0] rv;
  int n_mismatch = 0;
  int n_tests = 0;
  int gap = 0;
  int n;
  int ratio [4] = '{100, 50, 25, 12};
  logic [2:0] ml [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  always #2.5 sys_clk = ~sys_clk;
  // the pin reads the device clamp while it grounds the pin, else the part
  assign pin_wire = osc_pin_one_oe ? osc_pin_one_o : model_pin;

  sccs_top #(.MCD_CYCLES(MCD)) u_sccs_top (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .osc_pin_one_i(pin_wire), .osc_pin_one_o(osc_pin_one_o),
    .osc_pin_one_oe(osc_pin_one_oe), .sysclk_tick(sysclk_tick),
    .sysclk_ext(sysclk_ext), .int_osc_on(int_osc_on), .ext_osc_on(ext_osc_on),
    .mcd_reset(mcd_reset)
  );
  sccs_ext_clk_model u_sccs_ext_clk_model (
    .run(ext_run), .half_ns(16'h0064), .pin(model_pin)
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), 16'(sfr_rdata), 16'(e));
  endtask

  // plain read, as software polling a flag would do it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask

  // waits for the next tick, bounded so a dead clock still ends
  task automatic next_tick(output int c);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    while (sysclk_tick !== 1'b1 && c < 2000);
  endtask

  task automatic gapchk(input int e);
    int c;
    repeat (3) next_tick(c);
    check("tick gap", 16'(c), 16'(e));
  endtask

  task automatic wait_ext(input logic v);
    int c;
    c = 0;
    while (sysclk_ext !== v && c < 3000)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    check("source ext", 16'(sysclk_ext), 16'(v));
  endtask

  // spacing between ticks never falls below the fastest source period
  always @(posedge sys_clk)
  begin
    gap = rst ? 0 : gap + 1;
    if (sysclk_tick === 1'b1)
    begin
      check("min tick gap", 16'(gap >= 12), 16'h0001);
      gap = 0;
    end
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    ext_run = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("int on", 16'(int_osc_on), 16'h0000);
    check("ext on", 16'(ext_osc_on), 16'h0000);
    repeat (18) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(A_I, 8'h14);
    rdchk(A_X, 8'h00);
    check("pin clamp", 16'({osc_pin_one_oe, osc_pin_one_o}), 16'h0002);
    // unmapped place reads zero and swallows writes
    wr(8'hB3, 8'hFF);
    rdchk(8'hB3, 8'h00);
    rdchk(A_I, 8'h14);
    // unused bits ignore writes; disabled oscillator is never ready
    wr(A_I, 8'h63);
    rdchk(A_I, 8'h03);
    check("int on", 16'(int_osc_on), 16'h0000);
    for (int f = 3; f >= 0; f--)
    begin
      wr(A_I, 8'h04 | 8'(f));
      rdchk(A_I, 8'h04 | 8'(f));
      gapchk(ratio[f]);
      repeat (6) next_tick(n);
      rdchk(A_I, 8'h14 | 8'(f));
    end
    // every external mode with the part stopped; flag and reserved bit stay 0
    for (int m = 0; m < 8; m++)
    begin
      wr(A_X, {1'b1, 3'(m), 4'hF});
      rdchk(A_X, {1'b0, 3'(m), 4'h7});
      check("ext on", 16'(ext_osc_on), 16'(m >= 2));
      check("pin clamp", 16'(osc_pin_one_oe), 16'(m < 2));
    end
    // crystal start: mode set first, then poll valid before switching
    wr(A_X, 8'h67);
    ext_run <= 1'b1;
    rdchk(A_X, 8'h67);
    repeat (1000) @(posedge sys_clk);
    n = 0;
    do
    begin
      rd(A_X, rv);
      n++;
    end
    while (rv[7] !== 1'b1 && n < 100);
    rdchk(A_X, 8'hE7);
    wr(A_I, 8'h0C);
    wait_ext(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      wr(A_X, {1'b0, ml[i], 4'h7});
      gapchk((ml[i] == 3'h2 || ml[i] == 3'h6) ? 40 : 80);
      repeat (800) @(posedge sys_clk);
      rdchk(A_X, {ml[i][2] & ml[i][1], ml[i], 4'h7});
    end
    wr(A_I, 8'h04);
    wait_ext(1'b0);
    gapchk(100);
    // reset in mid-run from the external source
    wr(A_I, 8'h0C);
    wait_ext(1'b1);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("reset state", 16'({sysclk_ext, int_osc_on, ext_osc_on}), 16'h0000);
    repeat (19) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(A_I, 8'h14);
    check("source ext", 16'(sysclk_ext), 16'h0000);
    // missing-clock detector quiet while ticks come, fires once they stop
    wr(A_I, 8'h84);
    n = 0;
    repeat (1000)
    begin
      @(posedge sys_clk);
      #1;
      n += int'(mcd_reset === 1'b1);
    end
    check("mcd quiet", 16'(n), 16'h0000);
    wr(A_I, 8'h80);
    n = 0;
    while (mcd_reset !== 1'b1 && n < 2000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("mcd delay", 16'(gap >= MCD && gap <= MCD + 3), 16'h0001);
    @(posedge sys_clk);
    #1;
    check("mcd pulse", 16'(mcd_reset), 16'h0000);
    ext_run <= 1'b0;
    complete_run();
  end
endmodule

// >>> verilog/sccs_ext_osc.sv
// external oscillator input: synchroniser, edge tick, halving, stability
`timescale 1ns/1ps
module sccs_ext_osc (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // raw level sensed on oscillator pin one
  input wire logic pin_in,
  // source bundle
  sccs_src_if.ext_src s
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic phase;
    logic [7:0] gap;
    logic [4:0] edges;
    logic tick;
    logic stable;
  } sccs_ext_st_t;

  sccs_ext_st_t st_q, st_d;
  logic rise;

  // sync1 feeds only sync2; edges are seen between sync2 and prev
  assign rise = st_q.sync2 && !st_q.prev;

  // tick on rising edges, every other one when halved; stability needs
  // a run of edges with no long gap
  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    st_d.tick = 1'b0;
    if (!s.en)
    begin
      st_d.phase = 1'b0;
      st_d.gap = 8'h00;
      st_d.edges = 5'h00;
      st_d.stable = 1'b0;
    end
    else if (rise)
    begin
      st_d.gap = 8'h00;
      st_d.phase = s.div2 ? !st_q.phase : 1'b0;
      st_d.tick = !s.div2 || st_q.phase;
      if (st_q.edges == sccs_pkg::XTL_EDGES)
        st_d.stable = 1'b1;
      else
        st_d.edges = st_q.edges + 5'h01;
    end
    else if (st_q.gap == sccs_pkg::XTL_GAP_CYC)
    begin
      st_d.edges = 5'h00;
      st_d.stable = 1'b0;
    end
    else
      st_d.gap = st_q.gap + 8'h01;
  end

  // plain register of the whole state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign s.tick = st_q.tick;
  assign s.stable = st_q.stable;

  property p_ext_half;
    @(posedge sys_clk) disable iff (rst)
    (s.en && s.div2 && rise && !st_q.phase) |=> !s.tick;
  endproperty
  a_ext_half: assert property (p_ext_half)
    else $error("halved external clock ticked on odd edge");

endmodule

// >>> verilog/sccs_int_osc.sv
// internal oscillator: programmable tick divider with settle tracking
`timescale 1ns/1ps
module sccs_int_osc (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // source bundle
  sccs_src_if.int_src s
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ratio;
    logic [3:0] rdy_cnt;
    logic tick;
    logic stable;
  } sccs_int_st_t;

  sccs_int_st_t st_q, st_d;

  // divider and settle counter; a new ratio restarts settling
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    st_d.ratio = s.ratio;
    if (!s.en || (s.ratio != st_q.ratio))
    begin
      st_d.cnt = 8'h00;
      st_d.rdy_cnt = 4'h0;
      st_d.stable = 1'b0;
    end
    else if (st_q.cnt == s.ratio - 8'h01)
    begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
      if (st_q.rdy_cnt == sccs_pkg::INTERNAL_FREQ_READY_FLAG_TICKS - 4'h1)
        st_d.stable = 1'b1;
      else
        st_d.rdy_cnt = st_q.rdy_cnt + 4'h1;
    end
    else
      st_d.cnt = st_q.cnt + 8'h01;
  end

  // reset state matches the power-up setting, already settled
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_q <= '{cnt: 8'h00, ratio: 8'h64, rdy_cnt: 4'h0, tick: 1'b0, stable: 1'b1};
    else
      st_q <= st_d;
  end

  assign s.tick = st_q.tick;
  assign s.stable = st_q.stable;

  property p_int_period;
    @(posedge sys_clk) disable iff (rst)
    s.tick |-> $past(st_q.cnt) == $past(s.ratio) - 8'h01;
  endproperty
  a_int_period: assert property (p_int_period)
    else $error("internal tick off period");

  property p_int_resettle;
    @(posedge sys_clk) disable iff (rst)
    (s.en && $changed(s.ratio)) |=> !s.stable;
  endproperty
  a_int_resettle: assert property (p_int_resettle)
    else $error("ready flag kept over frequency change");

endmodule

// >>> verilog/sccs_pkg.sv
// constants, types and helpers for the system clock source control block
//
// Overview of operation
// - any reset leaves the internal oscillator selected
// - both oscillators stay off while reset held
// - source select bit picks internal or external
// - internal enable bit starts or stops internal oscillator
// - frequency field picks 2, 4, 8, 16 MHz
// - ready flag set only when at selected speed
// - detector enabled resets after 100 us clock gap
// - two unused bits read zero, writes ignored
// - modes 00x: external off, pin one grounded
// - mode 010 direct CMOS input, 011 halved
// - modes 10x: RC or capacitor, halved
// - mode 110 crystal, 111 crystal halved
// - crystal valid flag only in crystal modes
// - reserved bit reads zero, writes ignored
package sccs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EXT_CTRL = 8'hB1;
  localparam logic [7:0] ADDR_INT_CTRL = 8'hB2;
  localparam logic [7:0] INT_CTRL_RESET = 8'h14;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_CTRL_WMASK = 8'h8F;
  localparam logic [7:0] EXT_CTRL_WMASK = 8'h77;
  localparam int ICN_MCD_BIT = 7;
  localparam int ICN_RDY_BIT = 4;
  localparam int ICN_SEL_BIT = 3;
  localparam int ICN_EN_BIT = 2;
  localparam int ICN_FRQ_LSB = 0;
  localparam int XCN_VLD_BIT = 7;
  localparam int XCN_MODE_LSB = 4;
  localparam int XCN_FRQ_LSB = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int MCD_TIME_US = 100;
  localparam int MCD_CYCLES = MCD_TIME_US * CLK_MHZ;
  localparam logic [3:0] INTERNAL_FREQ_READY_FLAG_TICKS = 4'h8;
  localparam logic [7:0] XTL_GAP_CYC = 8'hFF;
  localparam logic [4:0] XTL_EDGES = 5'h10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_INT = 4'h1,
    SEL_TO_EXT = 4'h2,
    SEL_EXT = 4'h4,
    SEL_TO_INT = 4'h8
  } sccs_sel_t;

  // internal oscillator period in system cycles; 16 MHz rounds down to 12
  function automatic logic [7:0] sccs_int_ratio(input logic [1:0] frq);
    logic [7:0] r;
    r = 8'h64;
    unique case (frq)
      2'h0: r = 8'h64;
      2'h1: r = 8'h32;
      2'h2: r = 8'h19;
      2'h3: r = 8'h0C;
    endcase
    return r;
  endfunction

  // modes 00x leave the external circuit off
  function automatic logic sccs_ext_on(input logic [2:0] m);
    return m[2:1] != 2'h0;
  endfunction

  // modes that pass the external clock through a halving stage
  function automatic logic sccs_ext_div2(input logic [2:0] m);
    return (m == 3'h3) || (m[2:1] == 2'h2) || (m == 3'h7);
  endfunction

  // modes 11x use the crystal amplifier
  function automatic logic sccs_is_xtal(input logic [2:0] m);
    return m[2:1] == 2'h3;
  endfunction

endpackage

// >>> verilog/sccs_src_if.sv
// bundle between the top and one oscillator source model
`timescale 1ns/1ps
interface sccs_src_if;
  logic en;
  logic div2;
  logic [7:0] ratio;
  logic tick;
  logic stable;

  modport ctl (output en, output div2, output ratio, input tick, input stable);
  modport int_src (input en, input ratio, output tick, output stable);
  modport ext_src (input en, input div2, output tick, output stable);
endinterface

// >>> verilog/sccs_top.sv
// system clock source control: registers, source switch, missing-clock detector
`timescale 1ns/1ps
module sccs_top #(
  parameter int MCD_CYCLES = sccs_pkg::MCD_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // oscillator pin one
  input wire logic osc_pin_one_i,
  output logic osc_pin_one_o,
  output logic osc_pin_one_oe,
  // system clock and status
  output logic sysclk_tick,
  output logic sysclk_ext,
  output logic int_osc_on,
  output logic ext_osc_on,
  output logic mcd_reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] icn;
    logic [7:0] xcn;
    logic [7:0] rdata;
    sccs_pkg::sccs_sel_t sel;
    logic tick;
    logic [15:0] gap;
    logic mcd;
    logic int_on;
    logic ext_on;
    logic pin_gnd;
    logic arm;
  } sccs_top_st_t;

  sccs_top_st_t st_q, st_d;

  sccs_src_if int_if ();
  sccs_src_if ext_if ();

  logic [2:0] xmode;
  logic [1:0] ifrq;
  logic mcd_en;
  logic want_ext;
  logic int_en;
  logic int_rdy;
  logic xtl_vld;
  logic [7:0] icn_rd;
  logic [7:0] xcn_rd;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign xmode = st_q.xcn[sccs_pkg::XCN_MODE_LSB +: 3];
  assign ifrq = st_q.icn[sccs_pkg::ICN_FRQ_LSB +: 2];
  assign mcd_en = st_q.icn[sccs_pkg::ICN_MCD_BIT];
  assign want_ext = st_q.icn[sccs_pkg::ICN_SEL_BIT];
  assign int_en = st_q.icn[sccs_pkg::ICN_EN_BIT];
  assign int_rdy = int_en && int_if.stable;
  assign xtl_vld = sccs_pkg::sccs_is_xtal(xmode) && ext_if.stable;

  // source bundles; frequency field sets the internal period
  assign int_if.en = int_en;
  assign int_if.ratio = sccs_pkg::sccs_int_ratio(ifrq);
  assign int_if.div2 = 1'b0;
  assign ext_if.en = sccs_pkg::sccs_ext_on(xmode);
  assign ext_if.div2 = sccs_pkg::sccs_ext_div2(xmode);
  assign ext_if.ratio = 8'h00;

  // read images: unused bits 6:5 and the reserved bit read zero
  always_comb
  begin
    icn_rd = st_q.icn & sccs_pkg::INT_CTRL_WMASK;
    icn_rd[sccs_pkg::ICN_RDY_BIT] = int_rdy;
    xcn_rd = st_q.xcn & sccs_pkg::EXT_CTRL_WMASK;
    xcn_rd[sccs_pkg::XCN_VLD_BIT] = xtl_vld;
  end

  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  sccs_int_osc u_int (
    .sys_clk(sys_clk),
    .rst(rst),
    .s(int_if.int_src)
  );

  sccs_ext_osc u_ext (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(osc_pin_one_i),
    .s(ext_if.ext_src)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    st_d.mcd = 1'b0;
    // register writes touch only the writable bits
    if (sfr_wr && sfr_addr == sccs_pkg::ADDR_INT_CTRL)
      st_d.icn = sfr_wdata & sccs_pkg::INT_CTRL_WMASK;
    if (sfr_wr && sfr_addr == sccs_pkg::ADDR_EXT_CTRL)
      st_d.xcn = sfr_wdata & sccs_pkg::EXT_CTRL_WMASK;
    // reads are registered; unmapped addresses return zero
    if (sfr_rd)
    begin
      if (sfr_addr == sccs_pkg::ADDR_INT_CTRL)
        st_d.rdata = icn_rd;
      else if (sfr_addr == sccs_pkg::ADDR_EXT_CTRL)
        st_d.rdata = xcn_rd;
      else
        st_d.rdata = 8'h00;
    end
    // the switch only moves after a tick of the old source; the first
    // tick of the new one only aligns phase and the second is passed,
    // so no period is shorter than the new source's; a disabled old source
    // is left at once, a dead new source hangs until the detector fires
    unique case (st_q.sel)
      sccs_pkg::SEL_INT:
      begin
        st_d.tick = int_if.tick;
        if (want_ext && (int_if.tick || !int_en))
        begin
          st_d.sel = sccs_pkg::SEL_TO_EXT;
          st_d.arm = 1'b0;
        end
      end
      sccs_pkg::SEL_TO_EXT:
      begin
        if (!want_ext)
          st_d.sel = sccs_pkg::SEL_INT;
        else if (ext_if.tick && st_q.arm)
        begin
          st_d.tick = 1'b1;
          st_d.sel = sccs_pkg::SEL_EXT;
        end
        else if (ext_if.tick)
          st_d.arm = 1'b1;
      end
      sccs_pkg::SEL_EXT:
      begin
        st_d.tick = ext_if.tick;
        if (!want_ext && (ext_if.tick || !ext_if.en))
        begin
          st_d.sel = sccs_pkg::SEL_TO_INT;
          st_d.arm = 1'b0;
        end
      end
      sccs_pkg::SEL_TO_INT:
      begin
        if (want_ext)
        begin
          // back to the external source on its next full period
          if (ext_if.tick)
          begin
            st_d.tick = 1'b1;
            st_d.sel = sccs_pkg::SEL_EXT;
          end
        end
        else if (int_if.tick && st_q.arm)
        begin
          st_d.tick = 1'b1;
          st_d.sel = sccs_pkg::SEL_INT;
        end
        else if (int_if.tick)
          st_d.arm = 1'b1;
      end
      default: st_d.sel = sccs_pkg::SEL_INT;
    endcase
    // missing-clock detector: a gap of the full timeout raises a reset
    if (!mcd_en || st_q.tick)
      st_d.gap = 16'h0000;
    else if (st_q.gap == MCD_CYCLES[15:0])
    begin
      st_d.mcd = 1'b1;
      st_d.gap = 16'h0000;
    end
    else
      st_d.gap = st_q.gap + 16'h0001;
    // status images and the pin clamp
    st_d.int_on = int_en;
    st_d.ext_on = ext_if.en;
    st_d.pin_gnd = !ext_if.en;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset holds both oscillators off and returns to the internal source
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q.icn <= sccs_pkg::INT_CTRL_RESET & sccs_pkg::INT_CTRL_WMASK;
      st_q.xcn <= sccs_pkg::EXT_CTRL_RESET;
      st_q.rdata <= 8'h00;
      st_q.sel <= sccs_pkg::SEL_INT;
      st_q.tick <= 1'b0;
      st_q.gap <= 16'h0000;
      st_q.mcd <= 1'b0;
      st_q.int_on <= 1'b0;
      st_q.ext_on <= 1'b0;
      st_q.pin_gnd <= 1'b1;
      st_q.arm <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = st_q.rdata;
  assign osc_pin_one_o = 1'b0;
  assign osc_pin_one_oe = st_q.pin_gnd;
  assign sysclk_tick = st_q.tick;
  assign sysclk_ext = st_q.sel == sccs_pkg::SEL_EXT;
  assign int_osc_on = st_q.int_on;
  assign ext_osc_on = st_q.ext_on;
  assign mcd_reset = st_q.mcd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_internal;
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (st_q.sel == sccs_pkg::SEL_INT) && !int_osc_on && !ext_osc_on;
  endproperty
  a_reset_internal: assert property (p_reset_internal)
    else $error("not on internal source after reset");

  property p_ext_needs_select;
    @(posedge sys_clk) disable iff (rst)
    $rose(sysclk_ext) |-> $past(want_ext) && $past(ext_if.tick);
  endproperty
  a_ext_needs_select: assert property (p_ext_needs_select)
    else $error("external source taken without select");

  property p_int_off_no_tick;
    @(posedge sys_clk) disable iff (rst)
    !int_en ##1 !int_en |-> !int_if.tick;
  endproperty
  a_int_off_no_tick: assert property (p_int_off_no_tick)
    else $error("internal oscillator ticks while disabled");

  property p_mcd_timeout;
    @(posedge sys_clk) disable iff (rst)
    mcd_reset |-> $past(mcd_en) && $past(st_q.gap) == MCD_CYCLES[15:0];
  endproperty
  a_mcd_timeout: assert property (p_mcd_timeout)
    else $error("missing-clock reset at wrong time");

  property p_unused_zero;
    @(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == sccs_pkg::ADDR_INT_CTRL) |=> sfr_rdata[6:5] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits read nonzero");

  property p_pin_ground;
    @(posedge sys_clk) disable iff (rst)
    (xmode[2:1] == 2'h0) |=> osc_pin_one_oe && !osc_pin_one_o && !ext_if.tick;
  endproperty
  a_pin_ground: assert property (p_pin_ground)
    else $error("pin one not grounded in off mode");

  property p_valid_xtal_only;
    @(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == sccs_pkg::ADDR_EXT_CTRL && xmode[2:1] != 2'h3)
      |=> !sfr_rdata[7] && !sfr_rdata[3];
  endproperty
  a_valid_xtal_only: assert property (p_valid_xtal_only)
    else $error("crystal valid outside crystal mode");

  property p_no_runt;
    @(posedge sys_clk) disable iff (rst)
    sysclk_tick |=> !sysclk_tick;
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("system clock ticks back to back");

  property p_rdy_needs_enable;
    @(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == sccs_pkg::ADDR_INT_CTRL && !int_en)
      |=> !sfr_rdata[sccs_pkg::ICN_RDY_BIT];
  endproperty
  a_rdy_needs_enable: assert property (p_rdy_needs_enable)
    else $error("ready flag set while internal oscillator off");

endmodule
